// File: abch_assertions.sv
// Port checker for the ATA command handler
`timescale 1ns/10ps
module abch_assertions (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // Interrupt and media
    input wire logic irq,
    input wire abch_pkg::abch_media_in_t mediaIn,
    input wire abch_pkg::abch_media_out_t mediaOut
);
    logic [7:0] tf_r [0:7];
    logic [1:0] mask_r;
    logic wrDone;
    logic reqAny;
    assign wrDone = psel && penable && pready && pwrite;
    assign reqAny = mediaOut.eraseReq | mediaOut.flushReq | mediaOut.diagReq;
    // Shadow of the task file and mask as written by the host
    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < 8; i++) begin
                tf_r[i] <= 8'h00;
            end
            mask_r <= 2'h0;
        end else if (wrDone && paddr[11:5] == 7'h00) begin
            tf_r[paddr[4:2]] <= pwdata[7:0];
        end else if (wrDone && paddr == 12'h028) begin
            mask_r <= pwdata[1:0];
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_ready_timing: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("pready not one cycle after access start");
    a_ready_pulse: assert property (pready |-> psel && penable ##1 !pready)
        else $error("pready outside access or longer than one cycle");
    a_slverr_map: assert property (pready || pslverr |-> pready && (pslverr == (paddr > 12'h02c)))
        else $error("pslverr does not match address map");
    a_erase_addr: assert property (mediaOut.eraseReq |->
        mediaOut.startAddr == {tf_r[5][3:0], tf_r[4], tf_r[3], tf_r[2]} && mediaOut.blockCount == tf_r[1])
        else $error("erase start address or count wrong");
    a_req_single: assert property ($onehot0({mediaOut.eraseReq, mediaOut.flushReq, mediaOut.diagReq}))
        else $error("more than one media request");
    a_req_hold: assert property ($fell(reqAny) |-> $past(mediaIn.done, 2))
        else $error("media request dropped before done");
    a_req_drop: assert property ($rose(mediaIn.done) |-> ##[1:4] !reqAny)
        else $error("media request not dropped after done");
    a_irq_masked: assert property (mask_r == 2'h0 && $past(mask_r) == 2'h0 |-> !irq)
        else $error("irq high while all sources masked");
endmodule

// File: abch_ident_rom.sv
// Identify parameter block word table
`timescale 1ns/10ps
module abch_ident_rom (
    // Word select
    input wire logic [7:0] wordIdx,
    // Word value
    output logic [15:0] identWord
);
    always_comb begin
        case (wordIdx)
            8'd0: identWord = abch_pkg::IDW_CONFIG;
            8'd20: identWord = abch_pkg::IDW_BUFFER;
            8'd21: identWord = abch_pkg::IDW_BUFFER;
            8'd47: identWord = abch_pkg::IDW_MULTI;
            8'd49: identWord = abch_pkg::IDW_CAPS;
            8'd50: identWord = abch_pkg::IDW_CAPS2;
            8'd51: identWord = abch_pkg::IDW_PIO_TIMING;
            8'd53: identWord = abch_pkg::IDW_VALIDITY;
            8'd60: identWord = abch_pkg::DRIVE_SECTORS[15:0];
            8'd61: identWord = abch_pkg::DRIVE_SECTORS[31:16];
            8'd64: identWord = abch_pkg::IDW_ADV_PIO;
            8'd65: identWord = abch_pkg::IDW_CYCLE;
            8'd66: identWord = abch_pkg::IDW_CYCLE;
            8'd67: identWord = abch_pkg::IDW_CYCLE;
            8'd68: identWord = abch_pkg::IDW_CYCLE;
            8'd76: identWord = abch_pkg::IDW_SATA_CAPS;
            8'd78: identWord = abch_pkg::IDW_SATA_FEAT;
            // Reserved and unlisted words read as zero
            default: identWord = 16'h0000;
        endcase
    end
endmodule

// File: abch_media_model.sv
// Media engine stand-in answering erase, flush and diagnostic requests
`timescale 1ns/10ps
module abch_media_model #(parameter int DELAY = 6) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Scenario controls
    input wire logic faultSel,
    input wire logic standbySel,
    input wire logic slaveFailSel,
    input wire logic [7:0] codeSel,
    // Media side
    input wire abch_pkg::abch_media_out_t mediaOut,
    output abch_pkg::abch_media_in_t mediaIn
);
    int cnt_r;
    logic done_r;
    logic reqAny;
    assign reqAny = mediaOut.eraseReq | mediaOut.flushReq | mediaOut.diagReq;
    // Done only after the work, cache write-back included, has taken DELAY cycles
    always_ff @(posedge clock) begin
        if (rst || !reqAny) begin
            cnt_r <= 0;
            done_r <= 1'b0;
        end else if (cnt_r == DELAY) begin
            done_r <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 1;
        end
    end
    assign mediaIn = '{done: done_r, fault: faultSel, standby: standbySel,
        slaveFail: slaveFailSel, diagCode: codeSel};
endmodule

// File: abch_pkg.sv
// Constants and types for the ATA basic command handler
package abch_pkg;
    // Register byte offsets
    localparam logic [11:0] OFS_FEATURES = 12'h000;
    localparam logic [11:0] OFS_COUNT = 12'h004;
    localparam logic [11:0] OFS_ADDR_LOW = 12'h008;
    localparam logic [11:0] OFS_ADDR_MID = 12'h00c;
    localparam logic [11:0] OFS_ADDR_HIGH = 12'h010;
    localparam logic [11:0] OFS_DEV_HEAD = 12'h014;
    localparam logic [11:0] OFS_COMMAND = 12'h018;
    localparam logic [11:0] OFS_ERROR = 12'h01c;
    localparam logic [11:0] OFS_DATA = 12'h020;
    localparam logic [11:0] OFS_INT_STATUS = 12'h024;
    localparam logic [11:0] OFS_INT_MASK = 12'h028;
    localparam logic [11:0] OFS_CONTROL = 12'h02c;

    // Command codes
    localparam logic [7:0] CMD_POWER_A = 8'h98;
    localparam logic [7:0] CMD_POWER_B = 8'he5;
    localparam logic [7:0] CMD_ERASE = 8'hc0;
    localparam logic [7:0] CMD_DIAG = 8'h90;
    localparam logic [7:0] CMD_FLUSH = 8'he7;
    localparam logic [7:0] CMD_IDENT = 8'hec;

    // Status and error bit positions
    localparam int ST_BSY = 7;
    localparam int ST_RDY = 6;
    localparam int ST_DF = 5;
    localparam int ST_DSC = 4;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    localparam logic [7:0] ERR_ABORTED = 8'h04;
    localparam logic [7:0] STATUS_READY = 8'h50;
    localparam logic [7:0] STATUS_BUSY = 8'h80;
    localparam logic [7:0] STATUS_DRQ = 8'h58;
    localparam logic [7:0] STATUS_ABORT = 8'h51;
    localparam logic [7:0] STATUS_FAULT = 8'h71;

    // Result codes
    localparam logic [7:0] POWER_STANDBY = 8'h00;
    localparam logic [7:0] POWER_IDLE = 8'hff;
    localparam logic [7:0] DIAG_OK = 8'h01;
    localparam logic [7:0] DIAG_SLAVE_FAIL = 8'h80;

    // Interrupt bits and reset values
    localparam int INT_DONE = 0;
    localparam int INT_DRQ = 1;
    localparam logic [1:0] INT_MASK_RST = 2'h0;
    localparam logic FLUSH_EN_RST = 1'b1;
    localparam logic [7:0] IDENT_LAST = 8'hff;

    // Identify block words
    localparam logic [15:0] IDW_CONFIG = 16'h044a;
    localparam logic [15:0] IDW_BUFFER = 16'h0002;
    localparam logic [15:0] IDW_MULTI = 16'h8001;
    localparam logic [15:0] IDW_CAPS = 16'h0e00;
    localparam logic [15:0] IDW_CAPS2 = 16'h4000;
    localparam logic [15:0] IDW_PIO_TIMING = 16'h0200;
    localparam logic [15:0] IDW_VALIDITY = 16'h0007;
    localparam logic [15:0] IDW_ADV_PIO = 16'h0003;
    localparam logic [15:0] IDW_CYCLE = 16'h0078;
    localparam logic [15:0] IDW_SATA_CAPS = 16'h0006;
    localparam logic [15:0] IDW_SATA_FEAT = 16'h0008;
    localparam logic [31:0] DRIVE_SECTORS = 32'h0001_0000;

    // Media side handshake
    typedef struct packed {
        logic done;
        logic fault;
        logic standby;
        logic slaveFail;
        logic [7:0] diagCode;
    } abch_media_in_t;

    typedef struct packed {
        logic eraseReq;
        logic flushReq;
        logic diagReq;
        logic [27:0] startAddr;
        logic [7:0] blockCount;
    } abch_media_out_t;

    typedef enum logic [2:0] {
        S_IDLE,
        S_POWER,
        S_ERASE,
        S_DIAG,
        S_FLUSH,
        S_IDENT_PREP,
        S_IDENT
    } abch_state_t;
endpackage

// File: abch_top.sv
// ATA basic command handler: task file over APB, command engine, interrupt
// Operation
// - Power query in standby: count zero, interrupt
// - Power query when idle: count all ones
// - Erase conditions sectors; may report write fault
// - Erase address from head and address registers
// - Erase count gives consecutive sectors
// - Diagnostic ignores drive bit, reports both devices
// - Diagnostic result code lands in error register
// - Flush completes only after cache is written
// - Flush unsupported ends with aborted error
// - Identify returns block like single-sector read
// - Reserved identify bits and words are zero
`timescale 1ns/10ps
module abch_top (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Interrupt
    output logic irq,
    // Media engine
    input wire abch_pkg::abch_media_in_t mediaIn,
    output abch_pkg::abch_media_out_t mediaOut
);
    typedef struct packed {
        abch_pkg::abch_media_in_t sync1;
        abch_pkg::abch_media_in_t sync2;
        abch_pkg::abch_state_t state;
        logic [7:0] features;
        logic [7:0] count;
        logic [7:0] addrLow;
        logic [7:0] addrMid;
        logic [7:0] addrHigh;
        logic [7:0] devHead;
        logic [7:0] status;
        logic [7:0] error;
        logic [7:0] wordIdx;
        logic [1:0] intStatus;
        logic [1:0] intMask;
        logic flushEnable;
        abch_pkg::abch_media_out_t media;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
    } abch_regs_t;

    abch_regs_t r_r;
    abch_regs_t r_nxt;
    logic [15:0] identWord;
    logic accDone;
    logic wrDone;
    logic rdDone;
    logic taskFree;
    logic evDone;
    logic evDrq;
    logic [1:0] clearBits;

    abch_ident_rom identRom (
        .wordIdx(r_r.wordIdx),
        .identWord(identWord)
    );

    always_comb begin
        r_nxt = r_r;
        // Pins cross into the clock domain through two stages
        r_nxt.sync1 = mediaIn;
        r_nxt.sync2 = r_r.sync1;
        r_nxt.pready = 1'b0;
        r_nxt.pslverr = 1'b0;
        accDone = psel && penable && r_r.pready;
        wrDone = accDone && pwrite;
        rdDone = accDone && !pwrite;
        taskFree = !r_r.status[abch_pkg::ST_BSY] && !r_r.status[abch_pkg::ST_DRQ];
        evDone = 1'b0;
        evDrq = 1'b0;
        clearBits = 2'h0;

        // Access phase: answer one cycle after it opens
        if (psel && penable && !r_r.pready) begin
            r_nxt.pready = 1'b1;
            r_nxt.prdata = 32'h0000_0000;
            if (paddr == abch_pkg::OFS_FEATURES) begin
                r_nxt.prdata[7:0] = r_r.features;
            end else if (paddr == abch_pkg::OFS_COUNT) begin
                r_nxt.prdata[7:0] = r_r.count;
            end else if (paddr == abch_pkg::OFS_ADDR_LOW) begin
                r_nxt.prdata[7:0] = r_r.addrLow;
            end else if (paddr == abch_pkg::OFS_ADDR_MID) begin
                r_nxt.prdata[7:0] = r_r.addrMid;
            end else if (paddr == abch_pkg::OFS_ADDR_HIGH) begin
                r_nxt.prdata[7:0] = r_r.addrHigh;
            end else if (paddr == abch_pkg::OFS_DEV_HEAD) begin
                r_nxt.prdata[7:0] = r_r.devHead;
            end else if (paddr == abch_pkg::OFS_COMMAND) begin
                r_nxt.prdata[7:0] = r_r.status;
            end else if (paddr == abch_pkg::OFS_ERROR) begin
                r_nxt.prdata[7:0] = r_r.error;
            end else if (paddr == abch_pkg::OFS_DATA) begin
                if (r_r.status[abch_pkg::ST_DRQ]) begin
                    r_nxt.prdata[15:0] = identWord;
                end
            end else if (paddr == abch_pkg::OFS_INT_STATUS) begin
                r_nxt.prdata[1:0] = r_r.intStatus;
            end else if (paddr == abch_pkg::OFS_INT_MASK) begin
                r_nxt.prdata[1:0] = r_r.intMask;
            end else if (paddr == abch_pkg::OFS_CONTROL) begin
                r_nxt.prdata[0] = r_r.flushEnable;
            end else begin
                r_nxt.pslverr = 1'b1;
            end
        end

        // Register writes take effect at the completing edge
        if (wrDone) begin
            if (paddr == abch_pkg::OFS_INT_STATUS) begin
                clearBits = pwdata[1:0];
            end else if (paddr == abch_pkg::OFS_INT_MASK) begin
                r_nxt.intMask = pwdata[1:0];
            end else if (paddr == abch_pkg::OFS_CONTROL) begin
                r_nxt.flushEnable = pwdata[0];
            end else if (taskFree) begin
                // Task file is frozen while a command owns it
                if (paddr == abch_pkg::OFS_FEATURES) begin
                    r_nxt.features = pwdata[7:0];
                end else if (paddr == abch_pkg::OFS_COUNT) begin
                    r_nxt.count = pwdata[7:0];
                end else if (paddr == abch_pkg::OFS_ADDR_LOW) begin
                    r_nxt.addrLow = pwdata[7:0];
                end else if (paddr == abch_pkg::OFS_ADDR_MID) begin
                    r_nxt.addrMid = pwdata[7:0];
                end else if (paddr == abch_pkg::OFS_ADDR_HIGH) begin
                    r_nxt.addrHigh = pwdata[7:0];
                end else if (paddr == abch_pkg::OFS_DEV_HEAD) begin
                    r_nxt.devHead = pwdata[7:0];
                end else if (paddr == abch_pkg::OFS_COMMAND) begin
                    // Launch uses the task file as it stands now
                    r_nxt.status = abch_pkg::STATUS_BUSY;
                    r_nxt.error = 8'h00;
                    // Only erase looks at the parameter registers
                    case (pwdata[7:0])
                        abch_pkg::CMD_POWER_A, abch_pkg::CMD_POWER_B: begin
                            r_nxt.state = abch_pkg::S_POWER;
                        end
                        abch_pkg::CMD_ERASE: begin
                            r_nxt.state = abch_pkg::S_ERASE;
                            r_nxt.media.eraseReq = 1'b1;
                            r_nxt.media.startAddr = {r_r.devHead[3:0], r_r.addrHigh,
                                r_r.addrMid, r_r.addrLow};
                            r_nxt.media.blockCount = r_r.count;
                        end
                        abch_pkg::CMD_DIAG: begin
                            // Drive select plays no part here
                            r_nxt.state = abch_pkg::S_DIAG;
                            r_nxt.media.diagReq = 1'b1;
                        end
                        abch_pkg::CMD_FLUSH: begin
                            if (r_r.flushEnable) begin
                                r_nxt.state = abch_pkg::S_FLUSH;
                                r_nxt.media.flushReq = 1'b1;
                            end else begin
                                r_nxt.status = abch_pkg::STATUS_ABORT;
                                r_nxt.error = abch_pkg::ERR_ABORTED;
                                evDone = 1'b1;
                            end
                        end
                        abch_pkg::CMD_IDENT: begin
                            r_nxt.state = abch_pkg::S_IDENT_PREP;
                        end
                        default: begin
                            r_nxt.status = abch_pkg::STATUS_ABORT;
                            r_nxt.error = abch_pkg::ERR_ABORTED;
                            evDone = 1'b1;
                        end
                    endcase
                end
            end
        end

        // Command engine
        case (r_r.state)
            abch_pkg::S_IDLE: begin
                // Launch is decided by the command write above; keep its next state
            end
            abch_pkg::S_POWER: begin
                // Busy was held for one cycle before the result lands
                if (r_r.sync2.standby) begin
                    r_nxt.count = abch_pkg::POWER_STANDBY;
                end else begin
                    r_nxt.count = abch_pkg::POWER_IDLE;
                end
                r_nxt.status = abch_pkg::STATUS_READY;
                evDone = 1'b1;
                r_nxt.state = abch_pkg::S_IDLE;
            end
            abch_pkg::S_ERASE: begin
                if (r_r.sync2.done) begin
                    r_nxt.media.eraseReq = 1'b0;
                    if (r_r.sync2.fault) begin
                        r_nxt.status = abch_pkg::STATUS_FAULT;
                    end else begin
                        r_nxt.status = abch_pkg::STATUS_READY;
                    end
                    evDone = 1'b1;
                    r_nxt.state = abch_pkg::S_IDLE;
                end
            end
            abch_pkg::S_DIAG: begin
                if (r_r.sync2.done) begin
                    r_nxt.media.diagReq = 1'b0;
                    // Master folds the other device's outcome into its code
                    if (r_r.sync2.slaveFail) begin
                        r_nxt.error = r_r.sync2.diagCode | abch_pkg::DIAG_SLAVE_FAIL;
                    end else begin
                        r_nxt.error = r_r.sync2.diagCode;
                    end
                    r_nxt.status = abch_pkg::STATUS_READY;
                    evDone = 1'b1;
                    r_nxt.state = abch_pkg::S_IDLE;
                end
            end
            abch_pkg::S_FLUSH: begin
                // Ready and seek-complete only once the media reports done
                if (r_r.sync2.done) begin
                    r_nxt.media.flushReq = 1'b0;
                    r_nxt.status = abch_pkg::STATUS_READY;
                    evDone = 1'b1;
                    r_nxt.state = abch_pkg::S_IDLE;
                end
            end
            abch_pkg::S_IDENT_PREP: begin
                // Same as a one-sector PIO read: busy off, data request on
                r_nxt.wordIdx = 8'h00;
                r_nxt.status = abch_pkg::STATUS_DRQ;
                evDrq = 1'b1;
                r_nxt.state = abch_pkg::S_IDENT;
            end
            abch_pkg::S_IDENT: begin
                if (rdDone && paddr == abch_pkg::OFS_DATA) begin
                    if (r_r.wordIdx == abch_pkg::IDENT_LAST) begin
                        r_nxt.status = abch_pkg::STATUS_READY;
                        evDone = 1'b1;
                        r_nxt.state = abch_pkg::S_IDLE;
                    end else begin
                        r_nxt.wordIdx = r_r.wordIdx + 8'h01;
                    end
                end
            end
            default: begin
                r_nxt.state = abch_pkg::S_IDLE;
            end
        endcase

        // Sticky events: a set in the clearing cycle survives
        r_nxt.intStatus = (r_r.intStatus & ~clearBits) | {evDrq, evDone};
        r_nxt.irq = |(r_nxt.intStatus & r_nxt.intMask);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            r_r <= '0;
            r_r.state <= abch_pkg::S_IDLE;
            r_r.status <= abch_pkg::STATUS_READY;
            r_r.error <= abch_pkg::DIAG_OK;
            r_r.intMask <= abch_pkg::INT_MASK_RST;
            r_r.flushEnable <= abch_pkg::FLUSH_EN_RST;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign pready = r_r.pready;
    assign prdata = r_r.prdata;
    assign pslverr = r_r.pslverr;
    assign irq = r_r.irq;
    assign mediaOut = r_r.media;
endmodule

// File: ata_basic_command_handler_tb.sv
// Testbench for the ATA basic command handler
`timescale 1ns/10ps
module ata_basic_command_handler_tb;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic pready, pslverr, irq;
    logic [31:0] prdata, rv;
    logic faultSel = 1'b0;
    logic standbySel = 1'b0;
    logic slaveFailSel = 1'b0;
    logic [7:0] codeSel = 8'h01;
    abch_pkg::abch_media_in_t mediaIn;
    abch_pkg::abch_media_out_t mediaOut;
    int errors = 0;
    int samplesChecked = 0;

    initial begin
        forever #5 clock = ~clock;
    end

    abch_top dut_u (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
        .irq, .mediaIn, .mediaOut);
    abch_media_model media_u (.clock, .rst, .faultSel, .standbySel, .slaveFailSel, .codeSel, .mediaOut,
        .mediaIn);

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", samplesChecked, errors);
        if (errors == 0 && samplesChecked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
        output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                errors++;
                summarize();
            end
            @(posedge clock);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [11:0] a);
        logic e;
        apb(1'b0, a, 32'h0, rv, e);
    endtask

    // Polls status until busy clears, checks status, then the done interrupt unless data request is expected
    task automatic endCmd(input logic [7:0] st);
        int n;
        n = 0;
        rd(abch_pkg::OFS_COMMAND);
        while (rv[7] !== 1'b0) begin
            n++;
            if (n > 50) begin
                errors++;
                summarize();
            end
            rd(abch_pkg::OFS_COMMAND);
        end
        chk("status", rv, {24'h0, st});
        if (st[3] === 1'b1) begin
            return;
        end
        rd(abch_pkg::OFS_INT_STATUS);
        chk("done flag", rv & 32'h1, 32'h1);
        chk("irq set", {31'h0, irq}, 32'h1);
        wr(abch_pkg::OFS_INT_STATUS, 32'h3);
        @(posedge clock);
        chk("irq clear", {31'h0, irq}, 32'h0);
    endtask

    task automatic t_reset();
        logic e;
        rd(abch_pkg::OFS_COMMAND);
        chk("status reset", rv, 32'h50);
        rd(abch_pkg::OFS_ERROR);
        chk("error reset", rv, 32'h1);
        rd(abch_pkg::OFS_INT_MASK);
        chk("mask reset", rv, 32'h0);
        rd(abch_pkg::OFS_CONTROL);
        chk("control reset", rv, 32'h1);
        apb(1'b0, 12'h030, 32'h0, rv, e);
        chk("unmapped err", {31'h0, e}, 32'h1);
        chk("unmapped data", rv, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_power();
        for (int i = 0; i < 4; i++) begin
            standbySel <= i[0];
            wr(abch_pkg::OFS_COUNT, 32'h5a);
            wr(abch_pkg::OFS_COMMAND, i[1] ? 32'h98 : 32'he5);
            endCmd(8'h50);
            rd(abch_pkg::OFS_COUNT);
            chk("power count", rv, i[0] ? 32'h0 : 32'hff);
        end
        standbySel <= 1'b0;
        $display("test power done");
    endtask

    task automatic t_erase();
        for (int i = 0; i < 2; i++) begin
            faultSel <= i[0];
            wr(abch_pkg::OFS_ADDR_LOW, 32'h21);
            wr(abch_pkg::OFS_ADDR_MID, 32'h43);
            wr(abch_pkg::OFS_ADDR_HIGH, 32'h65);
            wr(abch_pkg::OFS_DEV_HEAD, 32'he7);
            wr(abch_pkg::OFS_COUNT, 32'h80 + i);
            wr(abch_pkg::OFS_COMMAND, 32'hc0);
            chk("erase req", {31'h0, mediaOut.eraseReq}, 32'h1);
            chk("erase addr", {4'h0, mediaOut.startAddr}, 32'h7654321);
            chk("erase count", {24'h0, mediaOut.blockCount}, 32'h80 + i);
            endCmd(i[0] ? 8'h71 : 8'h50);
        end
        faultSel <= 1'b0;
        $display("test erase done");
    endtask

    task automatic t_diag();
        for (int i = 1; i < 6; i++) begin
            codeSel <= i[7:0];
            slaveFailSel <= (i == 5);
            wr(abch_pkg::OFS_DEV_HEAD, i[0] ? 32'h10 : 32'h0);
            wr(abch_pkg::OFS_COMMAND, 32'h90);
            endCmd(8'h50);
            rd(abch_pkg::OFS_ERROR);
            chk("diag code", rv, (i == 5) ? 32'h85 : i);
        end
        slaveFailSel <= 1'b0;
        $display("test diag done");
    endtask

    task automatic t_flush();
        wr(abch_pkg::OFS_COMMAND, 32'he7);
        chk("flush req", {31'h0, mediaOut.flushReq}, 32'h1);
        rd(abch_pkg::OFS_COMMAND);
        chk("flush busy", rv, 32'h80);
        endCmd(8'h50);
        wr(abch_pkg::OFS_CONTROL, 32'h0);
        wr(abch_pkg::OFS_COMMAND, 32'he7);
        endCmd(8'h51);
        rd(abch_pkg::OFS_ERROR);
        chk("flush abort", rv, 32'h4);
        wr(abch_pkg::OFS_CONTROL, 32'h1);
        $display("test flush done");
    endtask

    task automatic t_ident();
        wr(abch_pkg::OFS_COMMAND, 32'hec);
        endCmd(8'h58);
        rd(abch_pkg::OFS_INT_STATUS);
        chk("data ready", rv & 32'h2, 32'h2);
        for (int w = 0; w < 256; w++) begin
            rd(abch_pkg::OFS_DATA);
            if (w == 0) begin
                chk("ident config", rv, 32'h044a);
            end else if (w == 47) begin
                chk("ident multi", rv, 32'h8001);
            end else if (w == 2 || w == 77 || (w >= 69 && w <= 75)) begin
                chk("ident reserved", rv, 32'h0);
            end
        end
        endCmd(8'h50);
        $display("test identify done");
    endtask

    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_reset();
        wr(abch_pkg::OFS_INT_MASK, 32'h3);
        t_power();
        t_erase();
        t_diag();
        t_flush();
        t_ident();
        summarize();
    end
endmodule

bind abch_top abch_assertions chk_u (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .irq, .mediaIn, .mediaOut);
